// file: verilog/vidsmp_cfg.svh
// Register offsets, field positions and reset values of the video input sampler.
// Assumes an 8-bit register port with byte-wide subaddresses.
`ifndef VIDSMP_CFG_SVH
`define VIDSMP_CFG_SVH
`define VS_ADDR_POL 8'h21
`define VS_ADDR_VOFF_LO 8'h23
`define VS_ADDR_VOFF_HI 8'h24
`define VS_ADDR_HOFF_LO 8'h25
`define VS_ADDR_HOFF_HI 8'h26
`define VS_ADDR_VLEN_LO 8'h27
`define VS_ADDR_VLEN_HI 8'h28
`define VS_ADDR_HLEN_LO 8'h29
`define VS_ADDR_HLEN_HI 8'h2a
`define VS_ADDR_CLAMP_START 8'h2b
`define VS_ADDR_CLAMP_END 8'h2c
`define VS_ADDR_GAIN_START 8'h2d
`define VS_ADDR_GAIN_END 8'h2e
`define VS_ADDR_STATUS 8'h30
`define VS_BIT_HPOL 0
`define VS_BIT_VPOL 1
`define VS_BIT_CLAMP_POL 2
`define VS_BIT_GAIN_POL 3
`define VS_BIT_SEQ 4
`define VS_BIT_EN 5
`define VS_POL_RESET 8'h00
`define VS_VOFF_RESET 11'h000
`define VS_HOFF_RESET 12'h000
`define VS_VLEN_RESET 11'h000
`define VS_HLEN_RESET 12'h000
`define VS_PULSE_RESET 8'h00
`endif

// file: verilog/vidsmp_pkg.sv
// Types shared by the video input sampler.
// Assumes vidsmp_cfg.svh holds the register offsets, bit positions and reset values; state encodings are set here.
package vidsmp_pkg;
    typedef enum logic [1:0] {
        VS_ST_WAIT = 2'b01,
        VS_ST_RUN = 2'b10
    } vidsmp_state_t;
    typedef logic [7:0] vidsmp_byte_t;
endpackage : vidsmp_pkg

// file: verilog/vidsmp_sync_norm.sv
// Sync pin synchroniser and polarity normaliser.
// Assumes an asynchronous sync pin; one clock, clock enable freezes state.
`timescale 1ns/1ns
`default_nettype none
module vidsmp_sync_norm (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic ce, // Clock enable
    input wire logic pin, // Raw sync pin
    input wire logic pol_high, // 1: sync active high
    output logic start_o, // One-cycle timing start
    output logic act_o // Sync active, normalised
);
    logic s1_r;
    logic s2_r;
    logic prev_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            prev_r <= s2_r;
        end
    end
    // End of the active pulse is the timing start in both polarities
    assign act_o = s2_r ^ ~pol_high;
    assign start_o = ce && (prev_r ^ ~pol_high) && !act_o;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_start_inactive;
        start_o |-> (pol_high ? !s2_r : s2_r) && (pol_high ? prev_r : !prev_r);
    endproperty
    a_start_inactive: assert property (p_start_inactive) else $error("start not at end of sync pulse");
endmodule : vidsmp_sync_norm
`default_nettype wire

// file: verilog/vidsmp_pulse_gen.sv
// Programmable pulse after the line start, with selectable output polarity.
// Assumes start_i is a one-cycle normalised line start.
`timescale 1ns/1ns
`default_nettype none
module vidsmp_pulse_gen #(
    parameter int CW = 9
) (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic ce, // Clock enable
    input wire logic start_i, // Line start pulse
    input wire logic [7:0] begin_i, // Cycles to pulse start
    input wire logic [7:0] end_i, // Cycles to pulse end
    input wire logic pol_high, // 1: pulse active high
    output logic out_r // Pulse pin level
);
    logic [CW-1:0] cnt_r;
    logic act;
    // Counter parks at all ones so no pulse repeats before the next line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '1;
        end else if (ce) begin
            if (start_i)
                cnt_r <= '0;
            else if (cnt_r != '1)
                cnt_r <= cnt_r + 1'b1;
        end
    end
    assign act = (cnt_r >= {1'b0, begin_i}) && (cnt_r < {1'b0, end_i});
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            out_r <= 1'b1;
        else if (ce)
            out_r <= pol_high ? act : !act;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_pulse_begin;
        (ce && start_i && begin_i == 8'h00 && end_i > 8'h01) ##1 ce |=> out_r == pol_high;
    endproperty
    a_pulse_begin: assert property (p_pulse_begin) else $error("pulse did not begin on time");
    property p_pulse_idle;
        (ce && !start_i && cnt_r >= {1'b0, end_i}) |=> out_r == !$past(pol_high);
    endproperty
    a_pulse_idle: assert property (p_pulse_idle) else $error("pulse level wrong when idle");
    c_pulse: cover property (ce && out_r == pol_high);
endmodule : vidsmp_pulse_gen
`default_nettype wire

// file: verilog/vidsmp_top.sv
// Input interface sync and sampling control of the video input path.
// Assumes sync and converter data pins are asynchronous and pass two flip-flops;
// register port is driven on SYS_CLK by a simple master.
`include "vidsmp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module vidsmp_top #(
    parameter int DW = 24,
    parameter int HW = 12,
    parameter int VW = 11
) (
    input wire logic SYS_CLK, // 50 MHz clock
    input wire logic RESET, // Async reset, active high
    input wire logic CE, // Clock enable
    input wire logic [7:0] ADDR, // Register address
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output vidsmp_pkg::vidsmp_byte_t RDATA, // Read data, cycle after RD
    input wire logic HORIZONTAL_SYNC_INPUT, // Horizontal sync pin
    input wire logic VERTICAL_SYNC_INPUT, // Vertical sync pin
    input wire logic [DW-1:0] PORT_GROUP0_DATA, // Converter 0 data
    input wire logic [DW-1:0] PORT_GROUP1_DATA, // Converter 1 data
    output logic CLAMP_PULSE, // Clamp pulse pin
    output logic GAIN_CORRECTION_PULSE, // Gain correction pulse pin
    output logic [DW-1:0] SMP_DATA, // Captured sample
    output logic SMP_VALID, // Sample valid
    output logic SMP_CONV // Converter of SMP_DATA
);
    import vidsmp_pkg::*;

    function automatic logic in_range(input logic [12:0] cnt, input logic [12:0] off, input logic [12:0] len);
        in_range = (cnt >= off) && (cnt < off + len);
    endfunction : in_range

    logic [7:0] pol_r;
    logic [VW-1:0] voff_r;
    logic [HW-1:0] hoff_r;
    logic [VW-1:0] vlen_r;
    logic [HW-1:0] hlen_r;
    logic [7:0] clamp_start_r;
    logic [7:0] clamp_end_r;
    logic [7:0] gain_start_r;
    logic [7:0] gain_end_r;
    vidsmp_byte_t rdata_r;
    logic [HW-1:0] hcnt_r;
    logic [VW-1:0] vcnt_r;
    logic phase_r;
    vidsmp_state_t st_r;
    vidsmp_state_t st_nxt;
    logic [DW-1:0] d0_s1_r;
    logic [DW-1:0] d0_s2_r;
    logic [DW-1:0] d1_s1_r;
    logic [DW-1:0] d1_s2_r;
    logic [DW-1:0] smp_data_r;
    logic smp_valid_r;
    logic smp_conv_r;

    wire h_start;
    wire v_start;
    wire h_act;
    wire v_act;
    wire smp_en = pol_r[`VS_BIT_EN];
    wire seq = pol_r[`VS_BIT_SEQ];
    wire wr_pol = WR && ADDR == `VS_ADDR_POL;
    wire wr_voff_lo = WR && ADDR == `VS_ADDR_VOFF_LO;
    wire wr_voff_hi = WR && ADDR == `VS_ADDR_VOFF_HI;
    wire wr_hoff_lo = WR && ADDR == `VS_ADDR_HOFF_LO;
    wire wr_hoff_hi = WR && ADDR == `VS_ADDR_HOFF_HI;
    wire wr_vlen_lo = WR && ADDR == `VS_ADDR_VLEN_LO;
    wire wr_vlen_hi = WR && ADDR == `VS_ADDR_VLEN_HI;
    wire wr_hlen_lo = WR && ADDR == `VS_ADDR_HLEN_LO;
    wire wr_hlen_hi = WR && ADDR == `VS_ADDR_HLEN_HI;
    wire [7:0] status = {3'h0, st_r == VS_ST_RUN, phase_r, smp_valid_r, v_act, h_act};
    wire [7:0] rdata_nxt = (RD && ADDR == `VS_ADDR_STATUS) ? status : 8'h00;
    wire h_win = in_range({1'b0, hcnt_r}, {1'b0, hoff_r}, {1'b0, hlen_r});
    wire v_win = in_range({2'b00, vcnt_r}, {2'b00, voff_r}, {2'b00, vlen_r});
    wire in_win = h_win && v_win && st_r == VS_ST_RUN;
    wire capture = smp_en && in_win;

    vidsmp_sync_norm u_hsync (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .pin(HORIZONTAL_SYNC_INPUT),
        .pol_high(pol_r[`VS_BIT_HPOL]),
        .start_o(h_start),
        .act_o(h_act)
    );
    vidsmp_sync_norm u_vsync (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .pin(VERTICAL_SYNC_INPUT),
        .pol_high(pol_r[`VS_BIT_VPOL]),
        .start_o(v_start),
        .act_o(v_act)
    );
    vidsmp_pulse_gen u_clamp (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .start_i(h_start),
        .begin_i(clamp_start_r),
        .end_i(clamp_end_r),
        .pol_high(pol_r[`VS_BIT_CLAMP_POL]),
        .out_r(CLAMP_PULSE)
    );
    vidsmp_pulse_gen u_gain (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .start_i(h_start),
        .begin_i(gain_start_r),
        .end_i(gain_end_r),
        .pol_high(pol_r[`VS_BIT_GAIN_POL]),
        .out_r(GAIN_CORRECTION_PULSE)
    );

    // Write-only registers; offsets and lengths split into low and high bytes
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pol_r <= `VS_POL_RESET;
            voff_r <= `VS_VOFF_RESET;
            hoff_r <= `VS_HOFF_RESET;
            vlen_r <= `VS_VLEN_RESET;
            hlen_r <= `VS_HLEN_RESET;
        end else if (CE) begin
            if (wr_pol)
                pol_r <= WDATA;
            if (wr_voff_lo)
                voff_r[7:0] <= WDATA;
            if (wr_voff_hi)
                voff_r[VW-1:8] <= WDATA[VW-9:0];
            if (wr_hoff_lo)
                hoff_r[7:0] <= WDATA;
            if (wr_hoff_hi)
                hoff_r[HW-1:8] <= WDATA[HW-9:0];
            if (wr_vlen_lo)
                vlen_r[7:0] <= WDATA;
            if (wr_vlen_hi)
                vlen_r[VW-1:8] <= WDATA[VW-9:0];
            if (wr_hlen_lo)
                hlen_r[7:0] <= WDATA;
            if (wr_hlen_hi)
                hlen_r[HW-1:8] <= WDATA[HW-9:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            clamp_start_r <= `VS_PULSE_RESET;
            clamp_end_r <= `VS_PULSE_RESET;
            gain_start_r <= `VS_PULSE_RESET;
            gain_end_r <= `VS_PULSE_RESET;
        end else if (CE && WR) begin
            if (ADDR == `VS_ADDR_CLAMP_START)
                clamp_start_r <= WDATA;
            if (ADDR == `VS_ADDR_CLAMP_END)
                clamp_end_r <= WDATA;
            if (ADDR == `VS_ADDR_GAIN_START)
                gain_start_r <= WDATA;
            if (ADDR == `VS_ADDR_GAIN_END)
                gain_end_r <= WDATA;
        end
    end

    // Only status reads back; the setup registers are write-only
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET)
            rdata_r <= 8'h00;
        else if (CE)
            rdata_r <= rdata_nxt;
    end
    assign RDATA = rdata_r;

    // Capture starts at a frame boundary so a half frame is never taken
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            VS_ST_WAIT: begin
                if (smp_en && v_start)
                    st_nxt = VS_ST_RUN;
            end
            VS_ST_RUN: begin
                if (!smp_en)
                    st_nxt = VS_ST_WAIT;
            end
            default: st_nxt = VS_ST_WAIT;
        endcase
    end

    // Data pins pass the same two stages as the sync pins to stay aligned
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            d0_s1_r <= '0;
            d0_s2_r <= '0;
            d1_s1_r <= '0;
            d1_s2_r <= '0;
        end else if (CE) begin
            d0_s1_r <= PORT_GROUP0_DATA;
            d0_s2_r <= d0_s1_r;
            d1_s1_r <= PORT_GROUP1_DATA;
            d1_s2_r <= d1_s1_r;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            st_r <= VS_ST_WAIT;
            hcnt_r <= '1;
            vcnt_r <= '1;
            phase_r <= 1'b0;
        end else if (CE) begin
            st_r <= st_nxt;
            if (h_start)
                hcnt_r <= '0;
            else if (hcnt_r != '1)
                hcnt_r <= hcnt_r + 1'b1;
            if (v_start)
                vcnt_r <= '0;
            else if (h_start && vcnt_r != '1)
                vcnt_r <= vcnt_r + 1'b1;
            phase_r <= h_start ? seq : !phase_r;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            smp_data_r <= '0;
            smp_valid_r <= 1'b0;
            smp_conv_r <= 1'b0;
        end else if (CE) begin
            smp_valid_r <= capture;
            if (capture) begin
                smp_data_r <= phase_r ? d1_s2_r : d0_s2_r;
                smp_conv_r <= phase_r;
            end
        end
    end
    assign SMP_DATA = smp_data_r;
    assign SMP_VALID = smp_valid_r;
    assign SMP_CONV = smp_conv_r;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    property p_hline;
        h_start |=> hcnt_r == '0;
    endproperty
    a_hline: assert property (p_hline) else $error("line count not restarted");
    property p_vframe;
        v_start |=> vcnt_r == '0;
    endproperty
    a_vframe: assert property (p_vframe) else $error("line number not restarted");
    property p_seq;
        h_start |=> phase_r == $past(seq);
    endproperty
    a_seq: assert property (p_seq) else $error("wrong converter first");
    property p_gate;
        (CE && !smp_en) |=> !SMP_VALID;
    endproperty
    a_gate: assert property (p_gate) else $error("capture while disabled");
    property p_hoff;
        (h_start && hoff_r != '0 && !wr_hoff_lo && !wr_hoff_hi) ##1 CE |=> !SMP_VALID;
    endproperty
    a_hoff: assert property (p_hoff) else $error("capture before horizontal offset");
    property p_window;
        (CE && (!h_win || !v_win)) |=> !SMP_VALID;
    endproperty
    a_window: assert property (p_window) else $error("capture outside window");
    property p_conv;
        (CE && capture) |=> SMP_CONV == $past(phase_r) && SMP_VALID;
    endproperty
    a_conv: assert property (p_conv) else $error("sample taken from wrong converter");
    property p_read;
        (CE && RD && ADDR == `VS_ADDR_STATUS) |=> RDATA == $past(status);
    endproperty
    a_read: assert property (p_read) else $error("status read wrong");
    property p_read_idle;
        (CE && !(RD && ADDR == `VS_ADDR_STATUS)) |=> RDATA == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not cleared");
    // A frame boundary must arm capture first, so no partial frame leaks out
    property p_armed;
        (CE && st_r == VS_ST_WAIT) |=> !SMP_VALID;
    endproperty
    a_armed: assert property (p_armed) else $error("capture before frame start");
    property p_phase;
        (CE && !h_start) |=> phase_r == !$past(phase_r);
    endproperty
    a_phase: assert property (p_phase) else $error("converters not alternating");
    // Lines advance only on line starts; saturation keeps a lost frame out of the window
    property p_vcount;
        (CE && h_start && !v_start && vcnt_r != '1) |=> vcnt_r == $past(vcnt_r) + 1'b1;
    endproperty
    a_vcount: assert property (p_vcount) else $error("line number not advanced");

    c_capture: cover property (CE && !SMP_VALID ##1 SMP_VALID);
    c_frame: cover property (st_r == VS_ST_WAIT ##1 st_r == VS_ST_RUN);
    c_seq1: cover property (h_start && seq);
    c_hoff: cover property (h_start && hoff_r != '0);
endmodule : vidsmp_top
`default_nettype wire

// file: verification/vidsmp_afe_model.sv
// Behavioural analogue front end: sync pins and two converter data groups.
// Assumes one clock shared with the sampler; pins change just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module vidsmp_afe_model #(
    parameter int DW = 24,
    parameter int LINE = 40,
    parameter int SW = 8,
    parameter int NL = 10
) (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic hpol, // 1: horizontal sync active high
    input wire logic vpol, // 1: vertical sync active high
    output logic hs, // Horizontal sync pin
    output logic vs, // Vertical sync pin
    output logic [DW-1:0] d0, // Converter 0 data
    output logic [DW-1:0] d1, // Converter 1 data
    output int hc, // Cycle within line
    output int lc // Line within frame
);
    logic [DW-2:0] cyc_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hc <= 0;
            lc <= 0;
            cyc_r <= '0;
        end else begin
            cyc_r <= cyc_r + 1'b1;
            hc <= (hc == LINE - 1) ? 0 : hc + 1;
            if (hc == LINE - 1) begin
                lc <= (lc == NL - 1) ? 0 : lc + 1;
            end
        end
    end
    // Active pulse at the start of each line, two lines of vertical sync per frame
    assign hs = (hc < SW) ? hpol : ~hpol;
    assign vs = (lc < 2) ? vpol : ~vpol;
    // Top bit names the converter; data changes every cycle so stale captures show
    assign d0 = {1'b0, cyc_r};
    assign d1 = {1'b1, ~cyc_r};
endmodule : vidsmp_afe_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the video input sampler with a behavioural front end.
// Assumes setup registers are write-only and only the status byte reads back.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("wrong value at %0t: got %h expected %h", $time, g, e); \
        end \
    end
module tb_top;
    localparam int DW = 24;
    localparam int LINE = 40;
    localparam int SW = 8;
    localparam int NL = 10;
    logic SYS_CLK = 0;
    logic RESET = 1;
    logic WR = 0;
    logic RD = 0;
    logic hpol = 0;
    logic vpol = 0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    vidsmp_pkg::vidsmp_byte_t RDATA;
    logic CLAMP, GAIN, SMP_VALID, SMP_CONV, hs, vs;
    logic [DW-1:0] SMP_DATA, d0, d1;
    int hc, lc;
    int fail_count = 0;
    int n_tests = 0;
    int cyc_n = 0;

    always #10 SYS_CLK = ~SYS_CLK;

    vidsmp_top #(.DW(DW)) vidsmp_top_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .CE(1'b1), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HORIZONTAL_SYNC_INPUT(hs), .VERTICAL_SYNC_INPUT(vs),
        .PORT_GROUP0_DATA(d0), .PORT_GROUP1_DATA(d1), .CLAMP_PULSE(CLAMP), .GAIN_CORRECTION_PULSE(GAIN),
        .SMP_DATA(SMP_DATA), .SMP_VALID(SMP_VALID), .SMP_CONV(SMP_CONV));
    vidsmp_afe_model #(.DW(DW), .LINE(LINE), .SW(SW), .NL(NL)) vidsmp_afe_model_inst (.clk(SYS_CLK),
        .rst(RESET), .hpol(hpol), .vpol(vpol), .hs(hs), .vs(vs), .d0(d0), .d1(d1), .hc(hc), .lc(lc));

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        @(posedge SYS_CLK);
        d = RDATA;
    endtask : rd

    task automatic wait_hc(input int n);
        do @(posedge SYS_CLK); while (hc != n);
    endtask : wait_hc

    task automatic wait_vs;
        do @(posedge SYS_CLK); while (!(lc == 2 && hc == 0));
    endtask : wait_vs

    // Latency from the line start edge to the active level, and its width
    task automatic meas(input bit g, input logic act, output int lat, output int wid);
        wait_hc(SW);
        lat = 0;
        wid = 0;
        for (int i = 1; i < LINE - 4; i++) begin
            @(posedge SYS_CLK);
            if ((g ? GAIN : CLAMP) === act) begin
                if (wid == 0) lat = i;
                wid++;
            end
        end
    endtask : meas

    task automatic t_status;
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            wr(8'h21, 8'(p));
            hpol <= p[0];
            repeat (2 * LINE) @(posedge SYS_CLK);
            wait_hc(4);
            rd(8'h30, d);
            `CHK(d[0], 1'b1)
            wait_hc(20);
            rd(8'h30, d);
            `CHK(d[0], 1'b0)
            `CHK(d[7:5], 3'h0)
        end
        rd(8'h21, d);
        `CHK(d, 8'h00)
        wr(8'h55, 8'hff);
        rd(8'h55, d);
        `CHK(d, 8'h00)
    endtask : t_status

    task automatic t_pulse;
        int l0, w0, g0, v0, l1, w1, g1, v1, ref_l;
        for (int p = 0; p < 2; p++) begin
            hpol <= p[0];
            wr(8'h21, {4'h0, ~p[0], p[0], 1'b0, p[0]});
            // Clamp start of zero exercises the pulse right after the line start
            wr(8'h2b, 8'h00);
            wr(8'h2c, 8'h04);
            wr(8'h2d, 8'h03);
            wr(8'h2e, 8'h09);
            repeat (2 * LINE) @(posedge SYS_CLK);
            wait_hc(SW);
            `CHK(CLAMP, ~p[0])
            `CHK(GAIN, p[0])
            meas(1'b0, p[0], l0, w0);
            meas(1'b1, ~p[0], g0, v0);
            `CHK(w0, 4)
            `CHK(v0, 6)
            `CHK(g0 - l0, 3)
            wr(8'h2b, 8'h05);
            wr(8'h2c, 8'h09);
            wr(8'h2d, 8'h08);
            wr(8'h2e, 8'h0e);
            meas(1'b0, p[0], l1, w1);
            meas(1'b1, ~p[0], g1, v1);
            `CHK(l1 - l0, 5)
            `CHK(w1, 4)
            `CHK(g1 - g0, 5)
            if (p == 0)
                ref_l = l0;
            else
                `CHK(l0, ref_l)
        end
    endtask : t_pulse

    task automatic t_frame(input int voff, input int hoff, input int vlen, input int hlen,
        input logic seq, input logic en, input logic vp, output int tot, output int fl, output int fh);
        logic prev_v, prev_c;
        logic [DW-2:0] cur_d, prev_d;
        int n;
        // Horizontal polarity bit is written as 0 below, so the front end must match
        hpol <= 1'b0;
        vpol <= vp;
        wr(8'h23, voff[7:0]);
        wr(8'h25, hoff[7:0]);
        wr(8'h27, vlen[7:0]);
        wr(8'h29, hlen[7:0]);
        wr(8'h21, {2'b00, en, seq, 2'b00, vp, 1'b0});
        // Two frames: the first may start before the new setup is armed
        wait_vs();
        wait_vs();
        tot = 0;
        fl = -1;
        fh = -1;
        prev_v = 0;
        prev_c = 0;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
            if (SMP_VALID === 1'b1) begin
                // Decoded front-end count steps by one per sample, so stale data shows
                cur_d = SMP_CONV ? ~SMP_DATA[DW-2:0] : SMP_DATA[DW-2:0];
                `CHK(SMP_DATA[DW-1], SMP_CONV)
                if (tot == 0) begin
                    fl = lc;
                    fh = hc;
                    `CHK(SMP_CONV, seq)
                end else if (prev_v) begin
                    `CHK(SMP_CONV, ~prev_c)
                    `CHK(cur_d, prev_d + 1'b1)
                end
                tot++;
            end
            prev_v = SMP_VALID;
            prev_c = SMP_CONV;
            prev_d = cur_d;
        end while (!(lc == 2 && hc == 0) && n < NL * LINE);
    endtask : t_frame

    task automatic t_frames;
        int t0, l0, h0, t1, l1, h1;
        t_frame(1, 0, 2, 5, 1'b0, 1'b1, 1'b0, t0, l0, h0);
        `CHK(t0, 10)
        t_frame(3, 4, 3, 6, 1'b1, 1'b1, 1'b1, t1, l1, h1);
        `CHK(t1, 18)
        `CHK(l1 - l0, 2)
        `CHK(h1 - h0, 4)
        t_frame(1, 0, 2, 5, 1'b0, 1'b0, 1'b0, t0, l0, h0);
        `CHK(t0, 0)
    endtask : t_frames

    // Whole run needs about 5000 cycles
    always @(posedge SYS_CLK) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge SYS_CLK);
        RESET <= 1'b0;
        t_status();
        t_pulse();
        t_frames();
        results();
    end
endmodule : tb_top
`default_nettype wire
